//--- include/bstx_map.svh
// Purpose: field positions, reset values and timing counts of the exec block
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef BSTX_MAP_SVH
`define BSTX_MAP_SVH

// reset values of held state
`define BSTX_ACC_RST      8'h00
`define BSTX_TABLE_HIGH_BYTE_RST     8'h00
`define BSTX_ZERO_RST     1'b0
// program word byte fields
`define BSTX_PW_LO_MSB    7
`define BSTX_PW_LO_LSB    0
`define BSTX_PW_HI_MSB    15
`define BSTX_PW_HI_LSB    8
// cycles a taken skip occupies, counting the execute cycle
`define BSTX_SKIP_CYCLES  2

`endif

//--- include/bstx_pkg.sv
// Purpose: types shared by the exec block files
// Assumes: nothing imported; users write bstx_pkg::name
// Notes:   codes are binary and fixed so the bench can drive op_in directly
package bstx_pkg;

	// instruction codes presented on op_in
	typedef enum logic [2:0] {
		BSTX_OP_SKIP_BIT  = 3'h0, // skip_if_bit_zero
		BSTX_OP_SKIP_MOVE = 3'h1, // skip_if_zero_move_to_acc
		BSTX_OP_TRD_CUR   = 3'h2, // table_read_current_page
		BSTX_OP_TRD_LAST  = 3'h3, // table_read_last_page
		BSTX_OP_XOR_ACC   = 3'h4, // accumulator ^= memory
		BSTX_OP_XOR_MEM   = 3'h5, // xor_into_memory
		BSTX_OP_XOR_IMM   = 3'h6  // accumulator ^= immediate
	} bstx_op_e;

	// sequencer states
	typedef enum logic [1:0] {
		BSTX_ST_IDLE  = 2'h0,
		BSTX_ST_OPER  = 2'h1,
		BSTX_ST_TABLE = 2'h2,
		BSTX_ST_DUMMY = 2'h3
	} bstx_state_e;

endpackage

//--- hw/bstx_data_ram.sv
// Purpose: data memory of the core, one write port and one registered read port
// Assumes: single clock, write and read in the same cycle return the old word
// Notes:   contents are not reset; software must initialise what it reads
module bstx_data_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// clock
	input  wire logic          clk_in,
	// write port
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] wr_addr_in,
	input  wire logic [DW-1:0] wr_data_in,
	// read port
	input  wire logic [AW-1:0] rd_addr_in,
	output logic      [DW-1:0] rd_data_out
);

	// storage array
	logic [DW-1:0] mem_reg [0:(1<<AW)-1];
	// read data register
	logic [DW-1:0] rd_data_reg;

	// write and registered read, no reset so it maps onto block ram
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
		rd_data_reg <= mem_reg[rd_addr_in];
	end

	assign rd_data_out = rd_data_reg;

endmodule

//--- hw/bstx_exec.sv
// Purpose: executes bit-skip, table-read and xor instructions of an 8-bit core
// Assumes: program memory returns the word one clock after pmem_addr_out changes
// Notes:   one instruction at a time; next accepted only while ready_out is high
`include "bstx_map.svh"

// What this block does
// - skip next instruction when tested bit zero
// - taken bit skip lasts two cycles
// - tested bit one continues without skip
// - current page table word low byte to memory
// - high byte to table high, flags untouched
// - last page table read, same byte routing
// - accumulator xor memory into accumulator, zero flag
// - xor result into memory, accumulator kept
// - accumulator xor immediate into accumulator
// - move byte to accumulator, skip if zero
module bstx_exec #(
	parameter int DM_AW = 8,  // data memory address width
	parameter int PG_W  = 3,  // program page number width
	parameter int PW    = 16  // program word width
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	// decoded instruction
	input  wire logic              instr_valid_in,
	input  wire logic [2:0]        op_in,
	input  wire logic [DM_AW-1:0]  mem_addr_in,
	input  wire logic [2:0]        bit_sel_in,
	input  wire logic [7:0]        imm_in,
	// core context
	input  wire logic [PG_W-1:0]   cur_page_in,
	input  wire logic [7:0]        table_pointer_in,
	// data memory preload from the core
	input  wire logic              dm_wr_in,
	input  wire logic [DM_AW-1:0]  dm_addr_in,
	input  wire logic [7:0]        dm_data_in,
	// program memory read port
	output logic [PG_W+7:0]        pmem_addr_out,
	input  wire logic [PW-1:0]     pmem_data_in,
	// status toward the core
	output logic                   ready_out,
	output logic                   done_out,
	output logic                   skip_next_out,
	output logic [7:0]             accumulator_out,
	output logic                   zero_flag_out,
	output logic [7:0]             table_high_byte_out
);

	// sequencer state
	bstx_pkg::bstx_state_e state_reg, state_next;
	// latched instruction fields
	bstx_pkg::bstx_op_e    op_reg, op_next;
	logic [DM_AW-1:0]      addr_reg, addr_next;
	logic [2:0]            bit_reg, bit_next;
	logic [7:0]            imm_reg, imm_next;
	// architectural state kept here
	logic [7:0]            acc_reg, acc_next;
	logic                  zero_reg, zero_next;
	logic [7:0]            table_high_byte_reg, table_high_byte_next;
	// registered outputs
	logic [PG_W+7:0]       paddr_reg, paddr_next;
	logic                  ready_reg, ready_next;
	logic                  done_reg, done_next;
	logic                  skip_reg, skip_next;
	// data memory ports
	logic                  ram_we;
	logic [DM_AW-1:0]      ram_waddr;
	logic [7:0]            ram_wdata;
	logic [DM_AW-1:0]      ram_raddr;
	logic [7:0]            ram_rdata;
	// helpers
	logic                  accept;
	logic [7:0]            xor_mem;
	logic [7:0]            xor_imm;

	// handshake: one instruction in flight
	assign accept  = instr_valid_in && ready_reg;
	assign xor_mem = acc_reg ^ ram_rdata;
	assign xor_imm = acc_reg ^ imm_reg;

	// data memory of the core
	bstx_data_ram #(
		.AW (DM_AW),
		.DW (8)
	) u_ram (
		.clk_in      (clk_in),
		.wr_en_in    (ram_we),
		.wr_addr_in  (ram_waddr),
		.wr_data_in  (ram_wdata),
		.rd_addr_in  (ram_raddr),
		.rd_data_out (ram_rdata)
	);

	// next-state and datapath computation
	always_comb begin
		state_next = state_reg;
		op_next    = op_reg;
		addr_next  = addr_reg;
		bit_next   = bit_reg;
		imm_next   = imm_reg;
		acc_next   = acc_reg;
		zero_next  = zero_reg;
		table_high_byte_next  = table_high_byte_reg;
		paddr_next = paddr_reg;
		done_next  = 1'b0;
		skip_next  = 1'b0;
		ram_we     = 1'b0;
		ram_waddr  = dm_addr_in;
		ram_wdata  = dm_data_in;
		// read address follows the incoming instruction so data is ready next cycle
		ram_raddr  = accept ? mem_addr_in : addr_reg;
		case (state_reg)
			bstx_pkg::BSTX_ST_IDLE: begin
				// core preload only while nothing executes, avoids a port clash
				ram_we = dm_wr_in;
				if (accept) begin
					op_next    = bstx_pkg::bstx_op_e'(op_in);
					addr_next  = mem_addr_in;
					bit_next   = bit_sel_in;
					imm_next   = imm_in;
					state_next = bstx_pkg::BSTX_ST_OPER;
					if (op_in == bstx_pkg::BSTX_OP_TRD_CUR) begin
						paddr_next = {cur_page_in, table_pointer_in};
					end
					else if (op_in == bstx_pkg::BSTX_OP_TRD_LAST) begin
						paddr_next = {{PG_W{1'b1}}, table_pointer_in};
					end
				end
			end
			bstx_pkg::BSTX_ST_OPER: begin
				state_next = bstx_pkg::BSTX_ST_IDLE;
				done_next  = 1'b1;
				case (op_reg)
					bstx_pkg::BSTX_OP_SKIP_BIT: begin
						if (!ram_rdata[bit_reg]) begin
							state_next = bstx_pkg::BSTX_ST_DUMMY;
							done_next  = 1'b0;
							skip_next  = 1'b1;
						end
						// bit one: plain completion, no skip
					end
					bstx_pkg::BSTX_OP_SKIP_MOVE: begin
						acc_next = ram_rdata;
						if (ram_rdata == 8'h00) begin
							state_next = bstx_pkg::BSTX_ST_DUMMY;
							done_next  = 1'b0;
							skip_next  = 1'b1;
						end
					end
					bstx_pkg::BSTX_OP_TRD_CUR,
					bstx_pkg::BSTX_OP_TRD_LAST: begin
						// word arrives one cycle after the address
						state_next = bstx_pkg::BSTX_ST_TABLE;
						done_next  = 1'b0;
					end
					bstx_pkg::BSTX_OP_XOR_ACC: begin
						acc_next  = xor_mem;
						zero_next = (xor_mem == 8'h00);
					end
					bstx_pkg::BSTX_OP_XOR_MEM: begin
						ram_we    = 1'b1;
						ram_waddr = addr_reg;
						ram_wdata = xor_mem;
						zero_next = (xor_mem == 8'h00);
					end
					bstx_pkg::BSTX_OP_XOR_IMM: begin
						acc_next  = xor_imm;
						zero_next = (xor_imm == 8'h00);
					end
					default: begin
						// unknown code completes as a no-op
					end
				endcase
			end
			bstx_pkg::BSTX_ST_TABLE: begin
				ram_we     = 1'b1;
				ram_waddr  = addr_reg;
				ram_wdata  = pmem_data_in[`BSTX_PW_LO_MSB:`BSTX_PW_LO_LSB];
				table_high_byte_next  = pmem_data_in[`BSTX_PW_HI_MSB:`BSTX_PW_HI_LSB];
				done_next  = 1'b1;
				state_next = bstx_pkg::BSTX_ST_IDLE;
			end
			bstx_pkg::BSTX_ST_DUMMY: begin
				done_next  = 1'b1;
				state_next = bstx_pkg::BSTX_ST_IDLE;
			end
			default: begin
				state_next = bstx_pkg::BSTX_ST_IDLE;
			end
		endcase
		// ready is registered so the core sees it a cycle ahead of acceptance
		ready_next = (state_next == bstx_pkg::BSTX_ST_IDLE) && !accept;
	end

	// state registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= bstx_pkg::BSTX_ST_IDLE;
			op_reg    <= bstx_pkg::BSTX_OP_SKIP_BIT;
			addr_reg  <= '0;
			bit_reg   <= 3'h0;
			imm_reg   <= 8'h00;
			acc_reg   <= `BSTX_ACC_RST;
			zero_reg  <= `BSTX_ZERO_RST;
			table_high_byte_reg  <= `BSTX_TABLE_HIGH_BYTE_RST;
			paddr_reg <= '0;
			ready_reg <= 1'b0;
			done_reg  <= 1'b0;
			skip_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			op_reg    <= op_next;
			addr_reg  <= addr_next;
			bit_reg   <= bit_next;
			imm_reg   <= imm_next;
			acc_reg   <= acc_next;
			zero_reg  <= zero_next;
			table_high_byte_reg  <= table_high_byte_next;
			paddr_reg <= paddr_next;
			ready_reg <= ready_next;
			done_reg  <= done_next;
			skip_reg  <= skip_next;
		end
	end

	// outputs straight from flip-flops
	assign pmem_addr_out       = paddr_reg;
	assign ready_out           = ready_reg;
	assign done_out            = done_reg;
	assign skip_next_out       = skip_reg;
	assign accumulator_out     = acc_reg;
	assign zero_flag_out       = zero_reg;
	assign table_high_byte_out = table_high_byte_reg;

endmodule

//--- tb/bstx_pmem_model.sv
// Purpose: program memory beside the exec block
// Assumes: the word answers one clock after the address
// Notes:   contents come from a formula, so no file is read
module bstx_pmem_model (
	// clock
	input  wire logic        clk_in,
	// read port
	input  wire logic [10:0] addr_in,
	output logic      [15:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// high byte = inverted pointer, low byte = pointer plus page times 32,
	// so a wrong page shows up in the low byte
	always_ff @(posedge clk_in) begin
		data_out <= {~addr_in[7:0], addr_in[7:0] + {addr_in[10:8], 5'h00}};
	end
endmodule

//--- tb/bstx_exec_chk.sv
// Purpose: timing and routing checks on the exec block ports
// Assumes: op codes as in bstx_pkg
// Notes:   bound into every instance of bstx_exec
module bstx_exec_chk #(
	parameter int PG_W = 3
) (
	// clock and reset
	input wire logic            clk_in,
	input wire logic            reset_in,
	// instruction side
	input wire logic            instr_valid_in,
	input wire logic [2:0]      op_in,
	input wire logic [PG_W-1:0] cur_page_in,
	input wire logic [7:0]      table_pointer_in,
	// results
	input wire logic [PG_W+7:0] pmem_addr_out,
	input wire logic            ready_out,
	input wire logic            done_out,
	input wire logic            skip_next_out,
	input wire logic [7:0]      accumulator_out,
	input wire logic            zero_flag_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// an instruction is taken on this edge
	wire take = instr_valid_in && ready_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_xor_two_cycles: assert property (take && op_in inside {3'h4, 3'h5, 3'h6} |=>
		!done_out ##1 done_out && ready_out) else $error("xor done not two cycles");
	a_table_three: assert property (take && op_in inside {3'h2, 3'h3} |=>
		!done_out [*2] ##1 done_out) else $error("table done not three cycles");
	a_cur_page_addr: assert property (take && op_in == 3'h2 |=>
		pmem_addr_out == {$past(cur_page_in), $past(table_pointer_in)})
		else $error("current page address wrong");
	a_last_page_addr: assert property (take && op_in == 3'h3 |=>
		pmem_addr_out == {{PG_W{1'b1}}, $past(table_pointer_in)})
		else $error("last page address wrong");
	a_table_flags_kept: assert property (take && op_in inside {3'h2, 3'h3} |=>
		($stable(zero_flag_out) && $stable(accumulator_out)) [*3])
		else $error("table read touched acc or zero");
	a_skip_then_done: assert property ($rose(skip_next_out) |=>
		done_out && !skip_next_out) else $error("skip pulse not followed by done");
	a_skip_source: assert property (skip_next_out |->
		$past(take, 2) && $past(op_in, 2) inside {3'h0, 3'h1})
		else $error("skip without skip instruction");
	a_xormem_keeps_acc: assert property (take && op_in == 3'h5 |=>
		$stable(accumulator_out) [*2]) else $error("memory xor changed acc");
	a_zero_from_result: assert property (take && op_in inside {3'h4, 3'h6} ##2 done_out |->
		zero_flag_out == (accumulator_out == 8'h00)) else $error("zero flag wrong");
	// main scenarios reached
	c_taken_skip: cover property (skip_next_out);
	c_last_page: cover property (take && op_in == 3'h3);
	c_zero_set: cover property ($rose(zero_flag_out));
endmodule

bind bstx_exec bstx_exec_chk #(.PG_W(PG_W)) u_chk (.*);

//--- tb/test_bit_skip_table_read_xor_exec.sv
// Purpose: self-checking bench of the exec block
// Assumes: default widths of the exec block
// Notes:   row = op, addr, imm, cycles, skip, acc, zero, table high
module test_bit_skip_table_read_xor_exec;
	timeunit 1ns;
	timeprecision 1ps;
	// imm also feeds pointer and bit select, low addr bits the page
	typedef struct packed {
		logic [3:0] op;
		logic [7:0] a;
		logic [7:0] imm;
		logic [3:0] n;
		logic [3:0] sk;
		logic [7:0] acc;
		logic [3:0] z;
		logic [7:0] th;
	} bstx_row_s;
	// memory 10 = 00, 11 = 81 at start; cycles are counted from the accepting
	// edge to the edge that raises done: one for plain work, two for a taken skip
	// or a table read; code 7 is the no-op and must leave every result alone
	bstx_row_s rows [15] = '{48'h6_00_3C_1_0_3C_0_00, 48'h4_11_00_1_0_BD_0_00,
		48'h6_00_BD_1_0_00_1_00, 48'h0_11_00_1_0_00_1_00, 48'h0_11_01_2_1_00_1_00,
		48'h0_11_07_1_0_00_1_00, 48'h1_10_00_2_1_00_1_00, 48'h1_11_00_1_0_81_1_00,
		48'h5_10_00_1_0_81_0_00, 48'h4_10_00_1_0_00_1_00, 48'h2_12_34_2_0_00_1_CB,
		48'h3_13_56_2_0_00_1_A9, 48'h4_12_00_1_0_74_0_A9, 48'h4_13_00_1_0_42_0_A9,
		48'h7_00_00_1_0_42_0_A9};
	logic        clk_in = 1'b0;
	logic        reset_in, instr_valid_in, dm_wr_in;
	logic        ready_out, done_out, skip_next_out, zero_flag_out;
	logic [2:0]  op_in, bit_sel_in, cur_page_in;
	logic [7:0]  mem_addr_in, imm_in, table_pointer_in, dm_addr_in, dm_data_in;
	logic [7:0]  accumulator_out, table_high_byte_out;
	logic [10:0] pmem_addr_out;
	logic [15:0] pmem_data_in;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cyc = 0;
	bstx_exec dut (.*);
	bstx_pmem_model pm (.clk_in(clk_in), .addr_in(pmem_addr_out), .data_out(pmem_data_in));
	// 125 MHz clock
	always #4 clk_in = ~clk_in;
	// hang guard, far above the fewer than one hundred cycles needed
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc > 2000) begin
			n_fail++;
			end_of_test();
		end
	end
	task end_of_test();
		if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one instruction; poke keeps valid and a memory write up while busy,
	// both of which must be ignored
	task run(input bstx_row_s r, input bit poke);
		int   n;
		logic sk;
		@(posedge clk_in);
		instr_valid_in <= 1'b1;
		op_in <= r.op[2:0];
		mem_addr_in <= r.a;
		imm_in <= r.imm;
		table_pointer_in <= r.imm;
		bit_sel_in <= r.imm[2:0];
		cur_page_in <= r.a[2:0];
		@(posedge clk_in);
		instr_valid_in <= poke;
		dm_wr_in <= poke;
		if (poke) imm_in <= ~r.imm;
		n = 0;
		sk = 1'b0;
		do begin
			@(posedge clk_in);
			instr_valid_in <= 1'b0;
			dm_wr_in <= 1'b0;
			#1 n++;
			sk = sk | (skip_next_out === 1'b1);
		end while (done_out !== 1'b1 && n < 6);
		cmp("cycles", {4'h0, r.n}, 8'(n));
		cmp("skip", {4'h0, r.sk}, {7'h00, sk});
		cmp("acc", r.acc, accumulator_out);
		cmp("zero", {4'h0, r.z}, {7'h00, zero_flag_out});
		cmp("table high", r.th, table_high_byte_out);
	endtask
	initial begin
		{instr_valid_in, dm_wr_in, op_in, bit_sel_in, cur_page_in} = '0;
		{mem_addr_in, imm_in, table_pointer_in, dm_addr_in, dm_data_in} = '0;
		reset_in = 1'b1;
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		// preload two bytes while idle
		@(posedge clk_in);
		dm_wr_in <= 1'b1;
		dm_addr_in <= 8'h10;
		@(posedge clk_in);
		dm_addr_in <= 8'h11;
		dm_data_in <= 8'h81;
		@(posedge clk_in);
		dm_wr_in <= 1'b0;
		dm_addr_in <= 8'h10;
		dm_data_in <= 8'h55;
		foreach (rows[i]) run(rows[i], 1'b0);
		// refused request and write while busy
		run(48'h6_00_0F_1_0_4D_0_A9, 1'b1);
		run(48'h4_10_00_1_0_CC_0_A9, 1'b0);
		// reset while idle clears state, memory survives
		@(posedge clk_in);
		reset_in <= 1'b1;
		@(posedge clk_in);
		#1 cmp("reset acc", 8'h00, accumulator_out);
		cmp("reset ready", 8'h00, {7'h00, ready_out});
		cmp("reset table high", 8'h00, table_high_byte_out);
		@(posedge clk_in);
		reset_in <= 1'b0;
		run(48'h4_10_00_1_0_81_0_00, 1'b0);
		end_of_test();
	end
endmodule
